// [logic/sld_lamp_driver.sv]
// status lamp driver: registers, power-state decode and lamp outputs
`timescale 1ns/1ps
`include "sld_consts.svh"

module sld_lamp_driver import sld_pkg::*; #(
    parameter int TICK_CYCLES = `SLD_TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // system power state
    input wire logic power_fail,
    input wire logic main_power_off,
    input wire logic deep_sleep_state,
    input wire logic light_sleep_state,
    // lamp pins
    output logic first_lamp_out,
    output logic second_lamp_out
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic [7:0] lamp_control_q;
    logic [7:0] lamp_blink_rate_q;
    logic [7:0] reg_rdata_q;
    logic [7:0] wave;
    logic hit_ctrl;
    logic hit_blink;
    logic lamp_arrangement;
    logic lamp_polarity;
    logic [1:0] state_mode;
    sld_blink_sel_t first_blink_sel;
    sld_blink_sel_t second_blink_sel;
    sld_pstate_e pstate;
    logic first_sw;
    logic second_sw;
    logic first_req;
    logic second_req;
    logic first_on;
    logic second_on;
    logic first_lamp_q;
    logic second_lamp_q;

    ////////////////////////////////////////////////////////////////////////
    // register port
    assign hit_ctrl = (reg_addr == `SLD_OFS_CTRL);
    assign hit_blink = (reg_addr == `SLD_OFS_BLINK);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lamp_control_q <= `SLD_CTRL_RST;
        end else if (reg_wr_en && hit_ctrl) begin
            lamp_control_q <= reg_wdata & `SLD_CTRL_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lamp_blink_rate_q <= `SLD_BLINK_RST;
        end else if (reg_wr_en && hit_blink) begin
            lamp_blink_rate_q <= reg_wdata & `SLD_BLINK_MASK;
        end
    end

    // read data lands one edge after the read strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata_q <= `SLD_RDATA_NONE;
        end else if (reg_rd_en) begin
            if (hit_ctrl) begin
                reg_rdata_q <= lamp_control_q;
            end else if (hit_blink) begin
                reg_rdata_q <= lamp_blink_rate_q;
            end else begin
                reg_rdata_q <= `SLD_RDATA_NONE;
            end
        end
    end

    assign reg_rdata = reg_rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // field extraction
    assign lamp_arrangement = lamp_control_q[`SLD_ARR_BIT];
    assign lamp_polarity = lamp_control_q[`SLD_POL_BIT];
    assign state_mode = lamp_control_q[`SLD_MODE_HI:`SLD_MODE_LO];
    assign second_blink_sel =
        lamp_blink_rate_q[`SLD_SEL2_HI:`SLD_SEL2_LO];
    assign first_blink_sel =
        lamp_blink_rate_q[`SLD_SEL1_HI:`SLD_SEL1_LO];

    ////////////////////////////////////////////////////////////////////////
    // blink timebase
    sld_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wave(wave)
    );

    assign first_sw = wave[first_blink_sel];
    assign second_sw = wave[second_blink_sel];

    ////////////////////////////////////////////////////////////////////////
    // power state, most severe condition first
    always_comb begin
        if (power_fail) begin
            pstate = SLD_PS_FAIL;
        end else if (main_power_off) begin
            pstate = SLD_PS_OFF;
        end else if (deep_sleep_state) begin
            pstate = SLD_PS_DEEP;
        end else if (light_sleep_state) begin
            pstate = SLD_PS_LIGHT;
        end else begin
            pstate = SLD_PS_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-state lamp requests
    always_comb begin
        first_req = first_sw;
        second_req = second_sw;
        unique case (pstate)
            SLD_PS_FAIL: begin
                first_req = 1'b0;
                second_req = 1'b0;
            end
            SLD_PS_OFF: begin
                if (state_mode == `SLD_MODE_OFF_BLINK) begin
                    first_req = wave[`SLD_BLK_1HZ];
                    second_req = wave[`SLD_BLK_1HZ];
                end else if (state_mode == `SLD_MODE_DEEP_OFF &&
                        deep_sleep_state) begin
                    // deep sleep darkens the lamps even with main off
                    first_req = 1'b0;
                    second_req = 1'b0;
                end
            end
            SLD_PS_DEEP: begin
                if (state_mode == `SLD_MODE_DEEP_OFF) begin
                    first_req = 1'b0;
                    second_req = 1'b0;
                end
            end
            SLD_PS_LIGHT: begin
                first_req = first_sw;
                second_req = second_sw;
            end
            SLD_PS_ON: begin
                first_req = first_sw;
                second_req = second_sw;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // lamp arrangement: a two-colour lamp shows one colour at a time
    always_comb begin
        if (lamp_arrangement == `SLD_ARR_DUAL) begin
            first_on = first_req && !second_req;
            second_on = second_req && !first_req;
        end else begin
            first_on = first_req;
            second_on = second_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output polarity
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            first_lamp_q <= 1'b0;
            second_lamp_q <= 1'b0;
        end else begin
            first_lamp_q <= first_on ^ lamp_polarity;
            second_lamp_q <= second_on ^ lamp_polarity;
        end
    end

    assign first_lamp_out = first_lamp_q;
    assign second_lamp_out = second_lamp_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_CTRL_RESET: assert property (
        !$past(rst_b) |-> lamp_control_q == `SLD_CTRL_RST)
        else $error("control register reset value wrong");

    AST_BLINK_RESET: assert property (
        !$past(rst_b) |-> lamp_blink_rate_q == `SLD_BLINK_RST)
        else $error("blink register reset value wrong");

    AST_RESERVED_ZERO: assert property (
        (lamp_control_q & ~`SLD_CTRL_MASK) == 8'h00 &&
        (lamp_blink_rate_q & ~`SLD_BLINK_MASK) == 8'h00)
        else $error("reserved bits not zero");

    AST_BLINK_WRITE: assert property (
        reg_wr_en && hit_blink |=>
        lamp_blink_rate_q == ($past(reg_wdata) & `SLD_BLINK_MASK))
        else $error("blink register write lost");

    AST_CTRL_READ: assert property (
        reg_rd_en && hit_ctrl && !reg_wr_en |=>
        reg_rdata == $past(lamp_control_q))
        else $error("control register read wrong");

    AST_UNMAPPED_READ: assert property (
        reg_rd_en && !hit_ctrl && !hit_blink |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    AST_FAIL_OFF: assert property (
        power_fail |=> first_lamp_out == $past(lamp_polarity) &&
        second_lamp_out == $past(lamp_polarity))
        else $error("lamps lit during power fail");

    AST_DEEP_OFF: assert property (
        !power_fail && !main_power_off && deep_sleep_state &&
        state_mode == `SLD_MODE_DEEP_OFF |=>
        first_lamp_out == $past(lamp_polarity) &&
        second_lamp_out == $past(lamp_polarity))
        else $error("lamps lit in deep sleep");

    AST_OFF_BLINK: assert property (
        !power_fail && main_power_off && lamp_arrangement &&
        state_mode == `SLD_MODE_OFF_BLINK |=>
        first_lamp_out == ($past(wave[`SLD_BLK_1HZ]) ^ $past(lamp_polarity)))
        else $error("power-off blink not 1 Hz");

    AST_ALWAYS_ON_LOW: assert property (
        pstate == SLD_PS_ON && lamp_arrangement && lamp_polarity &&
        first_blink_sel == `SLD_BLK_ON |=> !first_lamp_out)
        else $error("active-low lamp not driven low");

    AST_SECOND_INDEP: assert property (
        pstate == SLD_PS_ON && lamp_arrangement |=>
        second_lamp_out == ($past(second_sw) ^ $past(lamp_polarity)))
        else $error("second lamp not following its selector");

    AST_DUAL_EXCL: assert property (
        lamp_arrangement == `SLD_ARR_DUAL |=>
        !(first_lamp_out != $past(lamp_polarity) &&
          second_lamp_out != $past(lamp_polarity)))
        else $error("two-colour lamp driven with both colours");

    AST_CTRL_WRITE: assert property (
        reg_wr_en && hit_ctrl |=>
        lamp_control_q == ($past(reg_wdata) & `SLD_CTRL_MASK))
        else $error("control register write lost");

    AST_BLINK_READ: assert property (
        reg_rd_en && hit_blink && !reg_wr_en |=>
        reg_rdata == $past(lamp_blink_rate_q))
        else $error("blink register read wrong");

    AST_RDATA_HOLD: assert property (
        !reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_UNMAPPED_WRITE: assert property (
        reg_wr_en && !hit_ctrl && !hit_blink |=>
        $stable(lamp_control_q) && $stable(lamp_blink_rate_q))
        else $error("unmapped write changed a register");

    AST_DEEP_MAIN_OFF: assert property (
        !power_fail && main_power_off && deep_sleep_state &&
        state_mode == `SLD_MODE_DEEP_OFF |=>
        first_lamp_out == $past(lamp_polarity) &&
        second_lamp_out == $past(lamp_polarity))
        else $error("lamps lit in deep sleep with main off");

    AST_OFF_BLINK_SECOND: assert property (
        !power_fail && main_power_off && lamp_arrangement &&
        state_mode == `SLD_MODE_OFF_BLINK |=>
        second_lamp_out == ($past(wave[`SLD_BLK_1HZ]) ^ $past(lamp_polarity)))
        else $error("second lamp power-off blink wrong");

    AST_MODE00_SW: assert property (
        !power_fail && state_mode == `SLD_MODE_FAIL_ONLY &&
        lamp_arrangement |=>
        first_lamp_out == ($past(first_sw) ^ $past(lamp_polarity)) &&
        second_lamp_out == ($past(second_sw) ^ $past(lamp_polarity)))
        else $error("mode 00 lamps not following software");

    AST_MODE11_DEEP: assert property (
        !power_fail && !main_power_off && deep_sleep_state &&
        state_mode == `SLD_MODE_ALL_SW && lamp_arrangement |=>
        first_lamp_out == ($past(first_sw) ^ $past(lamp_polarity)) &&
        second_lamp_out == ($past(second_sw) ^ $past(lamp_polarity)))
        else $error("mode 11 deep sleep lamps wrong");

    AST_LIGHT_SW: assert property (
        pstate == SLD_PS_LIGHT && lamp_arrangement |=>
        first_lamp_out == ($past(first_sw) ^ $past(lamp_polarity)) &&
        second_lamp_out == ($past(second_sw) ^ $past(lamp_polarity)))
        else $error("light sleep lamps not following software");

    AST_ALWAYS_OFF: assert property (
        pstate == SLD_PS_ON && lamp_arrangement &&
        first_blink_sel == `SLD_BLK_OFF |=>
        first_lamp_out == $past(lamp_polarity))
        else $error("always-inactive lamp lit");

    AST_SECOND_ALWAYS_ON: assert property (
        pstate == SLD_PS_ON && lamp_arrangement &&
        second_blink_sel == `SLD_BLK_ON |=>
        second_lamp_out == !$past(lamp_polarity))
        else $error("always-active lamp dark");

    AST_POL_SWAP: assert property (
        lamp_arrangement == `SLD_ARR_DUAL && first_req && !second_req |=>
        first_lamp_out == !$past(lamp_polarity) &&
        second_lamp_out == $past(lamp_polarity))
        else $error("two-colour lamp colour wrong for polarity");

endmodule

// [logic/sld_consts.svh]
// constants for the status lamp driver
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

// register offsets and reset values
`define SLD_OFS_CTRL 5'h0A
`define SLD_OFS_BLINK 5'h0B
`define SLD_CTRL_RST 8'h00
`define SLD_BLINK_RST 8'h70
`define SLD_CTRL_MASK 8'h33
`define SLD_BLINK_MASK 8'h77
`define SLD_RDATA_NONE 8'h00

// field positions
`define SLD_ARR_BIT 5
`define SLD_POL_BIT 4
`define SLD_MODE_HI 1
`define SLD_MODE_LO 0
`define SLD_SEL2_HI 6
`define SLD_SEL2_LO 4
`define SLD_SEL1_HI 2
`define SLD_SEL1_LO 0

// lamp arrangement and state-mode codes
`define SLD_ARR_DUAL 1'b0
`define SLD_MODE_FAIL_ONLY 2'h0
`define SLD_MODE_OFF_BLINK 2'h1
`define SLD_MODE_DEEP_OFF 2'h2
`define SLD_MODE_ALL_SW 2'h3

// blink selector codes
`define SLD_BLK_OFF 3'h0
`define SLD_BLK_1HZ 3'h3
`define SLD_BLK_ON 3'h7

// timing: one frame is the slowest blink period
`define SLD_CLK_HZ 10000000
`define SLD_FRAME_MS 4000
`define SLD_FRAME_TICKS 96
`define SLD_TICK_CYCLES (`SLD_CLK_HZ / 1000 * `SLD_FRAME_MS / `SLD_FRAME_TICKS)

// blink periods and lit spans in ticks, for codes 1 to 6
`define SLD_PER_TICKS '{96, 48, 24, 12, 8, 6}
`define SLD_ON_TICKS '{12, 12, 12, 6, 4, 3}

`endif

// [logic/sld_pkg.sv]
// types for the status lamp driver
package sld_pkg;

    typedef logic [2:0] sld_blink_sel_t;

    typedef enum logic [4:0] {
        SLD_PS_FAIL = 5'h01,
        SLD_PS_OFF = 5'h02,
        SLD_PS_DEEP = 5'h04,
        SLD_PS_LIGHT = 5'h08,
        SLD_PS_ON = 5'h10
    } sld_pstate_e;

endpackage

// [logic/sld_timebase.sv]
// free-running blink timebase with one waveform per selector code
`timescale 1ns/1ps
`include "sld_consts.svh"

module sld_timebase import sld_pkg::*; #(
    parameter int TICK_CYCLES = `SLD_TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // waveforms indexed by blink selector
    output logic [7:0] wave
);

    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam int PER[6] = `SLD_PER_TICKS;
    localparam int ONT[6] = `SLD_ON_TICKS;
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);
    localparam logic [6:0] FRAME_LAST = 7'(`SLD_FRAME_TICKS - 1);

    logic [CW-1:0] div_q;
    logic [6:0] frame_q;
    logic tick;
    logic [7:0] wave_d;

    assign tick = (div_q == TICK_LAST);

    ////////////////////////////////////////////////////////////////////////
    // single shared counter chain keeps all phases coherent
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            frame_q <= '0;
        end else if (tick) begin
            frame_q <= (frame_q == FRAME_LAST) ? 7'h00 : frame_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lit at the start of each period
    assign wave_d[0] = 1'b0;
    assign wave_d[7] = 1'b1;
    for (genvar g = 0; g < 6; g++) begin : g_rate
        assign wave_d[g+1] = (frame_q % 7'(PER[g])) < 7'(ONT[g]);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wave <= 8'h00;
        end else begin
            wave <= wave_d;
        end
    end

    AST_FRAME_WRAP: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && frame_q == FRAME_LAST |=> frame_q == 7'h00)
        else $error("frame counter did not wrap");

    AST_FIXED_LEVELS: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !$past(rst_b) || (wave[0] == 1'b0 && wave[7] == 1'b1))
        else $error("fixed blink levels wrong");

endmodule

// [testbench/sld_lamp_model.sv]
// external indicator lamps hanging on the two lamp pins
`timescale 1ns/1ps
module sld_lamp_model (
    // lamp pins
    input wire logic first_pin,
    input wire logic second_pin,
    // board wiring
    input wire logic arrangement,
    input wire logic polarity,
    // light seen
    output logic lamp_a,
    output logic lamp_b
);
    logic on_level;
    assign on_level = ~polarity;
    always_comb begin
        if (arrangement) begin
            lamp_a = (first_pin === on_level);
            lamp_b = (second_pin === on_level);
        end else begin
            // current direction through the lamp picks the colour
            lamp_a = (first_pin === 1'b1) && (second_pin === 1'b0);
            lamp_b = (first_pin === 1'b0) && (second_pin === 1'b1);
        end
    end
endmodule

// [testbench/sld_lamp_driver_tb.sv]
// self-checking bench for the status lamp driver
`timescale 1ns/1ps
module sld_lamp_driver_tb;
    localparam int TICKS = 4;
    localparam int FRAME = 96 * TICKS;
    localparam int LIMIT = 20000;
    typedef struct {
        logic [7:0] ctrl;
        logic [7:0] blink;
        logic [3:0] ps;
        int k1;
        int k2;
    } sld_row_s;
    // kinds: 0 dark, 1 software setting, 2 fixed 1 Hz blink
    sld_row_s rows [27] = '{
        '{8'h20, 8'h70, 4'h0, 1, 1}, '{8'h20, 8'h61, 4'h0, 1, 1},
        '{8'h20, 8'h52, 4'h0, 1, 1}, '{8'h20, 8'h43, 4'h0, 1, 1},
        '{8'h20, 8'h34, 4'h0, 1, 1}, '{8'h20, 8'h25, 4'h0, 1, 1},
        '{8'h20, 8'h16, 4'h0, 1, 1}, '{8'h20, 8'h07, 4'h0, 1, 1},
        '{8'h20, 8'h77, 4'h8, 0, 0}, '{8'h20, 8'h77, 4'h6, 1, 1},
        '{8'h21, 8'h77, 4'h8, 0, 0}, '{8'h21, 8'h70, 4'h4, 2, 2},
        '{8'h21, 8'h25, 4'h2, 1, 1}, '{8'h21, 8'h25, 4'h0, 1, 1},
        '{8'h22, 8'h77, 4'h8, 0, 0}, '{8'h22, 8'h77, 4'h2, 0, 0},
        '{8'h22, 8'h77, 4'h1, 1, 1}, '{8'h22, 8'h77, 4'h6, 0, 0},
        '{8'h22, 8'h42, 4'h0, 1, 1}, '{8'h23, 8'h77, 4'h8, 0, 0},
        '{8'h23, 8'h77, 4'h2, 1, 1}, '{8'h23, 8'h13, 4'h1, 1, 1},
        '{8'h33, 8'h61, 4'h0, 1, 1}, '{8'h00, 8'h07, 4'h0, 1, 1},
        '{8'h00, 8'h70, 4'h0, 1, 1}, '{8'h00, 8'h77, 4'h0, 1, 1},
        '{8'h10, 8'h07, 4'h0, 1, 1}};
    logic core_clk, rst_b, reg_wr_en, reg_rd_en, arr, pol;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic power_fail, main_power_off, deep_sleep_state, light_sleep_state;
    logic first_lamp_out, second_lamp_out, lamp_a, lamp_b;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;

    sld_lamp_driver #(.TICK_CYCLES(TICKS)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_fail(power_fail), .main_power_off(main_power_off),
        .deep_sleep_state(deep_sleep_state),
        .light_sleep_state(light_sleep_state),
        .first_lamp_out(first_lamp_out), .second_lamp_out(second_lamp_out));
    sld_lamp_model i_lamps (
        .first_pin(first_lamp_out), .second_pin(second_lamp_out),
        .arrangement(arr), .polarity(pol), .lamp_a(lamp_a), .lamp_b(lamp_b));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr_en = 1'b1;
        @(posedge core_clk);
        #1 reg_wr_en = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge core_clk);
        #1 reg_rd_en = 1'b0;
        v = reg_rdata;
        @(posedge core_clk);
        #1;
    endtask

    // lit cycles over one frame
    function automatic int lit_for(int k, logic [2:0] sel);
        if (k == 0) return 0;
        if (k == 2) return FRAME / 2;
        case (sel)
            3'h0: return 0;
            3'h1: return FRAME / 8;
            3'h2: return FRAME / 4;
            3'h7: return FRAME;
            default: return FRAME / 2;
        endcase
    endfunction

    // rising edges over one frame
    function automatic int edg_for(int k, logic [2:0] sel);
        if (k == 0) return 0;
        if (k == 2) return 4;
        case (sel)
            3'h1: return 1;
            3'h2: return 2;
            3'h3: return 4;
            3'h4: return 8;
            3'h5: return 12;
            3'h6: return 16;
            default: return 0;
        endcase
    endfunction

    task automatic run_row(input sld_row_s r);
        int la, lb, ea, e1, e2, ta, tb2, t;
        logic prev;
        arr = r.ctrl[5];
        pol = r.ctrl[4];
        wr(5'h0A, r.ctrl);
        wr(5'h0B, r.blink);
        {power_fail, main_power_off, deep_sleep_state,
            light_sleep_state} = r.ps;
        repeat (8) @(posedge core_clk);
        #1;
        la = 0;
        lb = 0;
        ea = 0;
        prev = lamp_a;
        repeat (FRAME) begin
            @(posedge core_clk);
            #1;
            la += int'(lamp_a === 1'b1);
            lb += int'(lamp_b === 1'b1);
            ea += int'(lamp_a === 1'b1 && prev !== 1'b1);
            prev = lamp_a;
        end
        e1 = lit_for(r.k1, r.blink[2:0]);
        e2 = lit_for(r.k2, r.blink[6:4]);
        if (r.ctrl[5]) begin
            chk(la, e1);
            chk(lb, e2);
            chk(ea, edg_for(r.k1, r.blink[2:0]));
        end else begin
            ta = (e1 == FRAME && e2 == 0) ? FRAME : 0;
            tb2 = (e2 == FRAME && e1 == 0) ? FRAME : 0;
            if (r.ctrl[4]) begin
                t = ta;
                ta = tb2;
                tb2 = t;
            end
            chk(la, ta);
            chk(lb, tb2);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            results();
        end
    end

    initial begin
        rst_b = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        arr = 1'b0;
        pol = 1'b0;
        {power_fail, main_power_off, deep_sleep_state,
            light_sleep_state} = 4'h0;
        repeat (20) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(first_lamp_out, 1'b0);
        chk(second_lamp_out, 1'b1);
        rd(5'h0A, d);
        chk(d, 8'h00);
        rd(5'h0B, d);
        chk(d, 8'h70);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        wr(5'h0A, 8'hFF);
        rd(5'h0A, d);
        chk(d, 8'h33);
        wr(5'h0B, 8'hFF);
        rd(5'h0B, d);
        chk(d, 8'h77);
        wr(5'h0C, 8'h11);
        rd(5'h0C, d);
        chk(d, 8'h00);
        rd(5'h0B, d);
        chk(d, 8'h77);
        // read and write on one edge: old value comes back
        reg_addr = 5'h0B;
        reg_wdata = 8'h25;
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b1;
        @(posedge core_clk);
        #1 reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        chk(reg_rdata, 8'h77);
        @(posedge core_clk);
        #1 rd(5'h0B, d);
        chk(d, 8'h25);
        // back-to-back writes, then reset in mid-run
        reg_addr = 5'h0A;
        reg_wdata = 8'h23;
        reg_wr_en = 1'b1;
        @(posedge core_clk);
        #1 reg_addr = 5'h0B;
        reg_wdata = 8'h13;
        @(posedge core_clk);
        #1 reg_wr_en = 1'b0;
        rd(5'h0A, d);
        chk(d, 8'h23);
        rd(5'h0B, d);
        chk(d, 8'h13);
        rst_b = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_b = 1'b1;
        chk(reg_rdata, 8'h00);
        rd(5'h0A, d);
        chk(d, 8'h00);
        rd(5'h0B, d);
        chk(d, 8'h70);
        results();
    end
endmodule
